// File: hdl/stc_core.sv
// sysref timing calibration: configuration, status and measurement engine
`timescale 1ns/1ps

// Notes on behaviour
// - averaging code bits 3:2 selects 4, 16, 64 or 256 averages
// - more averages make the run longer and the delay value steadier
// - accumulation code bits 1:0 selects 4, 16, 64 or 256 cycles
// - a sysref period above the limit set by that code (128, 1664, 7808 or 32384 cycles) makes the run fail, no result
// - a run ends within 7296 times four to the (avg+acc+2) cycles
// - configuration register resets to 0x05
// - completion bit 17 reads 1 only while enabled and run completed
// - status bits 16:0 report the computed delay, valid only when complete
// - result bit 16 says the sampling clock is inverted
// - result bits 15:8 hold the coarse delay step
// - result bits 7:0 hold the fine delay step
// - status is read only; bits 23:18 and all fields read zero after reset
// - enable rising edge starts a run; while enabled automatic delay is used
module stc_core
#(
    parameter logic [31:0] BOUND_SCALE = stc_pkg::STC_BOUND_SCALE
)
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire stc_pkg::stc_reg_req_s reg_req_in,
    input wire logic cal_enable_in,
    input wire logic sysref_in,
    output logic [23:0] reg_rdata_out,
    output logic [16:0] cal_delay_result_out,
    output logic cal_complete_flag_out,
    output logic cal_auto_mode_out,
    output logic cal_fail_out
);
    import stc_pkg::*;

    // all state lives in one struct; next_r is its combinational copy
    stc_state_s r;
    stc_state_s next_r;

    // ----------------------------------------
    // derived values
    // ----------------------------------------
    logic sys_edge;
    logic en_rise;
    logic [14:0] period_limit;
    logic [8:0] acc_len;
    logic [8:0] avg_num;
    logic [31:0] bound;
    logic [4:0] res_exp;
    logic [16:0] frac;
    logic complete;

    always_comb
    begin
        sys_edge = sysref_in & ~r.sys_q;
        en_rise = cal_enable_in & ~r.en_q;
        acc_len = 9'(STC_COUNT_BASE << {r.acc_sel, 1'b0});
        avg_num = 9'(STC_COUNT_BASE << {r.avg_sel, 1'b0});
        // limits follow the latched code, not the live register
        unique case (r.acc_sel)
            2'h0: period_limit = STC_PERIOD_LIMIT_0;
            2'h1: period_limit = STC_PERIOD_LIMIT_1;
            2'h2: period_limit = STC_PERIOD_LIMIT_2;
            2'h3: period_limit = STC_PERIOD_LIMIT_3;
        endcase
        // exponent of four in the bound, doubled into a shift of two
        res_exp = 5'({r.avg_sel, 1'b0}) + 5'({r.acc_sel, 1'b0}) + 5'h04;
        // checked in every measuring state, so a dead sysref cannot hang a run
        bound = 32'(BOUND_SCALE << res_exp);
        // scale the summed high count to a fraction of 2^16 of the window
        frac = 17'(r.sum << (STC_RESULT_EXP - res_exp));
        // gated by enable so that a disable hides a stale result at once
        complete = cal_enable_in & r.done;
    end

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic cfg_wr;
    logic cfg_rd;
    logic st_rd;

    always_comb
    begin
        cfg_wr = reg_req_in.wr & (reg_req_in.addr == STC_CONFIG_ADDR);
        // a read beside a write in one cycle returns the value held before it
        cfg_rd = reg_req_in.rd & (reg_req_in.addr == STC_CONFIG_ADDR);
        st_rd = reg_req_in.rd & (reg_req_in.addr == STC_STATUS_ADDR);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.en_q = cal_enable_in;
        next_r.sys_q = sysref_in;
        // period counter restarts on every sysref edge, so it runs while idle too
        next_r.per_cnt = sys_edge ? 15'h0001 : 15'(r.per_cnt + 15'h0001);
        // run timer wraps harmlessly while idle because a start reloads it
        next_r.tmo_cnt = 32'(r.tmo_cnt + 32'h00000001);
        // configuration write; reserved bits 7:4 are plain storage
        if (cfg_wr)
        begin
            next_r.config_reg = reg_req_in.wdata;
        end
        if (!cal_enable_in)
        begin
            next_r.state = STC_IDLE;
            next_r.done = 1'b0;
        end
        else if (en_rise)
        begin
            // codes are latched so a write mid-run cannot skew the counts
            next_r.state = STC_SYNC;
            next_r.done = 1'b0;
            next_r.avg_sel = r.config_reg[STC_AVG_LSB +: 2];
            next_r.acc_sel = r.config_reg[STC_ACC_LSB +: 2];
            next_r.tmo_cnt = 32'h00000001;
            next_r.sum = 17'h00000;
            next_r.avg_cnt = 9'h000;
        end
        else
        begin
            unique case (r.state)
                STC_IDLE, STC_DONE, STC_FAIL:
                begin
                end
                STC_SYNC:
                begin
                    // first edge only anchors the period measurement
                    if (r.tmo_cnt >= bound)
                        next_r.state = STC_FAIL;
                    else if (sys_edge)
                        next_r.state = STC_WAIT;
                end
                STC_WAIT:
                begin
                    if (r.per_cnt > period_limit || r.tmo_cnt >= bound)
                        next_r.state = STC_FAIL;
                    else if (sys_edge)
                    begin
                        next_r.state = STC_ACCUM;
                        next_r.len_cnt = acc_len;
                    end
                end
                STC_ACCUM:
                begin
                    // one sample per cycle; the sum cannot outgrow the sample window
                    next_r.sum = 17'(r.sum + {16'h0000, sysref_in});
                    next_r.len_cnt = 9'(r.len_cnt - 9'h001);
                    if (r.per_cnt > period_limit || r.tmo_cnt >= bound)
                        next_r.state = STC_FAIL;
                    else if (r.len_cnt == 9'h001)
                    begin
                        next_r.avg_cnt = 9'(r.avg_cnt + 9'h001);
                        if (9'(r.avg_cnt + 9'h001) == avg_num)
                            next_r.state = STC_DONE;
                        else
                            next_r.state = STC_WAIT;
                    end
                end
                default:
                    next_r.state = STC_IDLE;
            endcase
        end
        // result is taken once the last accumulation has been folded in
        if (r.state == STC_DONE && !r.done && cal_enable_in && !en_rise)
        begin
            next_r.done = 1'b1;
            next_r.result[STC_INV_BIT] = frac[16] | frac[15];
            next_r.result[STC_COARSE_LSB +: 8] = {frac[14:8], 1'b0};
            next_r.result[STC_FINE_LSB +: 8] = frac[7:0];
        end
        // status is read only; writes to it fall through untouched
        if (cfg_rd)
        begin
            next_r.rdata = {16'h0000, r.config_reg};
        end
        else if (st_rd)
        begin
            next_r.rdata = {6'h00, complete, r.result};
        end
        else if (reg_req_in.rd)
        begin
            // unmapped reads return zero rather than stale data
            next_r.rdata = 24'h000000;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            // select copies start equal to the register's reset codes
            r <= '0;
            r.state <= STC_IDLE;
            r.config_reg <= STC_CONFIG_RESET;
            r.avg_sel <= STC_CONFIG_RESET[STC_AVG_LSB +: 2];
            r.acc_sel <= STC_CONFIG_RESET[STC_ACC_LSB +: 2];
        end
        else
        begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata_out = r.rdata;
    assign cal_delay_result_out = r.result;
    assign cal_complete_flag_out = complete;
    assign cal_auto_mode_out = cal_enable_in;
    // no status bit for failure; software sees a run that never completes
    assign cal_fail_out = cal_enable_in & (r.state == STC_FAIL);
endmodule

// File: hdl/stc_pkg.sv
// package of constants, types and register layout for the sysref timing calibration
package stc_pkg;
    // ----------------------------------------
    // register map and field layout
    // ----------------------------------------
    localparam logic [11:0] STC_CONFIG_ADDR = 12'h2b1;
    localparam logic [11:0] STC_STATUS_ADDR = 12'h2b2;
    localparam logic [7:0] STC_CONFIG_RESET = 8'h05;
    localparam int STC_AVG_LSB = 2;
    localparam int STC_ACC_LSB = 0;
    localparam int STC_DONE_BIT = 17;
    localparam int STC_INV_BIT = 16;
    localparam int STC_COARSE_LSB = 8;
    localparam int STC_FINE_LSB = 0;
    // ----------------------------------------
    // timing counts, in sampling-clock cycles
    // ----------------------------------------
    localparam logic [8:0] STC_COUNT_BASE = 9'h004;
    localparam logic [14:0] STC_PERIOD_LIMIT_0 = 15'h0080;
    localparam logic [14:0] STC_PERIOD_LIMIT_1 = 15'h0680;
    localparam logic [14:0] STC_PERIOD_LIMIT_2 = 15'h1e80;
    localparam logic [14:0] STC_PERIOD_LIMIT_3 = 15'h7e80;
    localparam logic [31:0] STC_BOUND_SCALE = 32'h00001c80;
    localparam logic [4:0] STC_RESULT_EXP = 5'h10;

    typedef enum logic [2:0]
    {
        STC_IDLE = 3'b000,
        STC_SYNC = 3'b001,
        STC_WAIT = 3'b010,
        STC_ACCUM = 3'b011,
        STC_DONE = 3'b100,
        STC_FAIL = 3'b101
    } stc_state_e;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } stc_reg_req_s;

    typedef struct packed
    {
        stc_state_e state;
        logic [7:0] config_reg;
        logic [1:0] avg_sel;
        logic [1:0] acc_sel;
        logic en_q;
        logic sys_q;
        logic [8:0] len_cnt;
        logic [8:0] avg_cnt;
        logic [14:0] per_cnt;
        logic [31:0] tmo_cnt;
        logic [16:0] sum;
        logic [16:0] result;
        logic done;
        logic [23:0] rdata;
    } stc_state_s;
endpackage

// File: tb/stc_checker.sv
// checker of register and completion behaviour at the calibration ports
`timescale 1ns/1ps
module stc_checker
import stc_pkg::*;
#(
    parameter logic [31:0] BOUND_SCALE = STC_BOUND_SCALE
)
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire stc_pkg::stc_reg_req_s reg_req_in,
    input wire logic cal_enable_in,
    input wire logic sysref_in,
    input wire logic [23:0] reg_rdata_out,
    input wire logic [16:0] cal_delay_result_out,
    input wire logic cal_complete_flag_out,
    input wire logic cal_auto_mode_out,
    input wire logic cal_fail_out
);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_rd_st;
        reg_req_in.rd && reg_req_in.addr == STC_STATUS_ADDR;
    endsequence
    sequence s_rd_cfg;
        reg_req_in.rd && reg_req_in.addr == STC_CONFIG_ADDR;
    endsequence
    property p_auto;
        cal_auto_mode_out == cal_enable_in;
    endproperty
    property p_done_en;
        cal_complete_flag_out |-> cal_enable_in;
    endproperty
    property p_drop;
        $fell(cal_enable_in) |-> !cal_complete_flag_out;
    endproperty
    // done is already clear in the first enabled cycle; the next two cycles are checked
    property p_start;
        $rose(cal_enable_in) |=> !cal_complete_flag_out [*2];
    endproperty
    property p_rd_st;
        s_rd_st |=> reg_rdata_out ==
            {6'h0, $past(cal_complete_flag_out), $past(cal_delay_result_out)};
    endproperty
    property p_rsv;
        reg_rdata_out[23:18] == 6'h0;
    endproperty
    property p_rd_cfg;
        s_rd_cfg |=> reg_rdata_out[23:8] == 16'h0;
    endproperty
    property p_hold;
        cal_complete_flag_out && $past(cal_complete_flag_out) |-> $stable(cal_delay_result_out);
    endproperty
    property p_excl;
        !(cal_fail_out && cal_complete_flag_out);
    endproperty
    a_auto: assert property (p_auto) else $error("auto mode off enable");
    a_done_en: assert property (p_done_en) else $error("done without enable");
    a_drop: assert property (p_drop) else $error("done after drop");
    a_start: assert property (p_start) else $error("done too soon");
    a_rd_st: assert property (p_rd_st) else $error("status read wrong");
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    a_rd_cfg: assert property (p_rd_cfg) else $error("config upper bits");
    a_hold: assert property (p_hold) else $error("result moved");
    a_excl: assert property (p_excl) else $error("fail and done");
endmodule
bind stc_core stc_checker #(.BOUND_SCALE(BOUND_SCALE)) i_chk(.mclk_in, .arst_n_in, .reg_req_in,
    .cal_enable_in, .sysref_in, .reg_rdata_out, .cal_delay_result_out,
    .cal_complete_flag_out, .cal_auto_mode_out, .cal_fail_out);

// File: tb/stc_sysref_src.sv
// sysref source model at the far side of the calibration block
`timescale 1ns/1ps
module stc_sysref_src
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [15:0] period_in,
    input wire logic [15:0] high_in,
    output logic sysref_out
);
    logic [15:0] cnt;
    // ----------------
    // period counter
    // ----------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cnt <= 16'h0;
        else
            cnt <= (cnt + 16'h1 >= period_in) ? 16'h0 : cnt + 16'h1;
    end
    // period stays in limit unless a fail scenario sets it long
    assign sysref_out = cnt < high_in;
endmodule

// File: tb/tb_top.sv
// self-checking bench for the sysref timing calibration block
`timescale 1ns/1ps
module tb_top;
import stc_pkg::*;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    stc_reg_req_s req = '0;
    logic en = 1'b0;
    logic sysref;
    logic [15:0] per = 16'h10;
    logic [15:0] hi = 16'h8;
    logic [23:0] rdata;
    logic [16:0] res;
    logic done;
    logic fail;
    logic [31:0] seed = 32'h0000fa57;
    logic [31:0] x;
    logic [23:0] v;
    logic [16:0] er;
    int error_cnt = 0;
    int num_checks = 0;
    int c0;
    int c1;
    int p;
    always #10 mclk_in = ~mclk_in;
    stc_sysref_src i_src(.clk_in(mclk_in), .arst_n_in(arst_n_in), .period_in(per),
        .high_in(hi), .sysref_out(sysref));
    stc_core i_dut(.mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_req_in(req),
        .cal_enable_in(en), .sysref_in(sysref), .reg_rdata_out(rdata),
        .cal_delay_result_out(res), .cal_complete_flag_out(done),
        .cal_auto_mode_out(), .cal_fail_out(fail));
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int bound(input int s);
        return 384 * 19 * (4 ** s);
    endfunction
    task automatic results();
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s", $time, m);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_in) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_in) req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [23:0] d);
        @(posedge mclk_in) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h0};
        @(posedge mclk_in) req <= '0;
        #1 d = rdata;
    endtask
    task automatic run(input logic [1:0] a, input logic [1:0] c, input logic ok,
        input logic [16:0] exp_res, output int n);
        int lim;
        // wait is capped well below the rule's bound to keep the run short
        lim = (bound(a + c + 2) < 20000) ? bound(a + c + 2) : 20000;
        wr(STC_CONFIG_ADDR, {4'h0, a, c});
        @(posedge mclk_in) en <= 1'b1;
        n = 0;
        while (done !== 1'b1 && fail !== 1'b1 && n < lim)
        begin
            @(posedge mclk_in);
            #1 n++;
        end
        chk(24'(n < lim), 24'h1, "run too long");
        if (n >= lim)
            results();
        chk(24'({done, fail}), 24'({ok, !ok}), "run outcome");
        rd(STC_STATUS_ADDR, v);
        if (ok)
            chk(v, {6'h0, 1'b1, exp_res}, "status after run");
        else
            chk(24'(v[17]), 24'h0, "done after fail");
        @(posedge mclk_in) en <= 1'b0;
        #1 chk(24'(done), 24'h0, "done after drop");
        rd(STC_STATUS_ADDR, v);
        chk(24'(v[17]), 24'h0, "status done after drop");
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        repeat (6) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        rd(STC_CONFIG_ADDR, v);
        chk(v, 24'h5, "config reset");
        wr(STC_STATUS_ADDR, 8'hff);
        rd(STC_STATUS_ADDR, v);
        chk(v, 24'h0, "status not clear");
        rd(12'h2b3, v);
        chk(v, 24'h0, "unmapped read");
        repeat (4)
        begin
            x = xs();
            wr(STC_CONFIG_ADDR, x[7:0]);
            rd(STC_CONFIG_ADDR, v);
            chk(v, {16'h0, x[7:0]}, "config readback");
        end
        // every code of both fields, with a short and a long high time
        for (int i = 0; i < 4; i++)
        begin
            x = xs();
            p = (8 << (6 - 2 * i)) + int'(x[3:0]);
            per <= 16'(p);
            hi <= (i == 1) ? 16'h1 : 16'(p - 1);
            er = (i != 1) ? 17'h10000 : 17'h00000;
            run(2'(i), 2'(3 - i), 1'b1, er, c0);
        end
        per <= 16'h14;
        hi <= 16'h13;
        run(2'h0, 2'h0, 1'b1, 17'h10000, c0);
        run(2'h1, 2'h0, 1'b1, 17'h10000, c1);
        chk(24'(c1 > c0), 24'h1, "more averages not longer");
        // a quarter of each window high gives a nonzero coarse step
        per <= 16'h8;
        hi <= 16'h2;
        run(2'h0, 2'h0, 1'b1, 17'h08000, c0);
        per <= 16'hc8;
        hi <= 16'h64;
        run(2'h0, 2'h0, 1'b0, 17'h00000, c0);
        results();
    end
endmodule
